/* hw/vrc_ctl_if.sv */
// Link between the register bank and its startup timer
`timescale 1ns/1ps
interface vrc_ctl_if;
    logic ref_on;
    logic stable;

    modport ctl (output ref_on, input stable);
    modport tmr (input ref_on, output stable);
endinterface : vrc_ctl_if

/* hw/vrc_pkg.sv */
// Constants, offsets and helpers shared by the voltage reference controls
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package vrc_pkg;

    // ------------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------------
    localparam logic [7:0] ADDR_TRIM = 8'h00;
    localparam logic [7:0] ADDR_SC   = 8'h01;
    localparam logic [7:0] ADDR_ISTA = 8'h02;
    localparam logic [7:0] ADDR_IMSK = 8'h03;

    // ------------------------------------------------------------------------
    // Field positions and encodings
    // ------------------------------------------------------------------------
    localparam int         SC_EN_BIT   = 7;
    localparam int         SC_ST_BIT   = 2;
    localparam logic [1:0] MODE_STBY   = 2'h0;
    localparam logic [1:0] MODE_LP     = 2'h1;
    localparam logic [1:0] MODE_TR     = 2'h2;
    localparam logic [1:0] MODE_RSVD   = 2'h3;
    localparam int         EV_STABLE   = 0;
    localparam int         EV_LOST     = 1;
    localparam int         EV_RSVD     = 2;
    localparam int         EV_W        = 3;

    // ------------------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------------------
    localparam logic [7:0]      TRIM_RST    = 8'hff;
    localparam logic [1:0]      MODE_RST    = 2'h0;
    localparam logic [EV_W-1:0] IMSK_RST    = 3'h0;
    localparam int              STARTUP_CYC = 500;

    // Reserved mode is treated as off so the analog side never sees it
    function automatic logic ref_active(input logic en, input logic [1:0] mode);
        ref_active = en && (mode != MODE_RSVD);
    endfunction : ref_active

endpackage : vrc_pkg

/* hw/vrc_regs.sv */
// Register bank and analog enable decode for the voltage reference
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module vrc_regs #(
    parameter int STARTUP_CYCLES = vrc_pkg::STARTUP_CYC
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rd_data,
    output logic      [7:0] trim_code,
    output logic            bandgap_on,
    output logic            lp_buf_on,
    output logic            tr_buf_on,
    output logic            irq
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [7:0]               trim_reg;
    logic                     en_reg;
    logic [1:0]               mode_reg;
    logic [vrc_pkg::EV_W-1:0] ista_reg;
    logic [vrc_pkg::EV_W-1:0] ista_next;
    logic [vrc_pkg::EV_W-1:0] imsk_reg;
    logic [vrc_pkg::EV_W-1:0] ev;
    logic                     stable_d_reg;
    logic                     bandgap_reg;
    logic                     lp_reg;
    logic                     tr_reg;
    logic                     irq_reg;
    logic [7:0]               rd_data_reg;
    logic [7:0]               rd_mux;
    logic                     wr_trim;
    logic                     wr_sc;
    logic                     wr_ista;
    logic                     wr_imsk;
    logic                     active;

    vrc_ctl_if u_if ();

    // ------------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------------
    assign wr_trim = wr_en && (addr == vrc_pkg::ADDR_TRIM);
    assign wr_sc   = wr_en && (addr == vrc_pkg::ADDR_SC);
    assign wr_ista = wr_en && (addr == vrc_pkg::ADDR_ISTA);
    assign wr_imsk = wr_en && (addr == vrc_pkg::ADDR_IMSK);

    assign active    = vrc_pkg::ref_active(en_reg, mode_reg);
    assign u_if.ref_on = active;

    // ------------------------------------------------------------------------
    // Trim register
    // ------------------------------------------------------------------------
    // The code passes straight through; its odd ordering is the analog side's
    always_ff @(posedge core_clk) begin
        if (rst) begin
            trim_reg <= vrc_pkg::TRIM_RST;
        end else if (wr_trim) begin
            trim_reg <= wr_data;
        end
    end

    // ------------------------------------------------------------------------
    // Status and control register
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            en_reg <= 1'b0;
        end else if (wr_sc) begin
            en_reg <= wr_data[vrc_pkg::SC_EN_BIT];
        end
    end

    // The reserved code is stored as written so software reads back its value
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_reg <= vrc_pkg::MODE_RST;
        end else if (wr_sc) begin
            mode_reg <= wr_data[1:0];
        end
    end

    // ------------------------------------------------------------------------
    // Startup timer
    // ------------------------------------------------------------------------
    vrc_startup #(
        .STARTUP_CYCLES (STARTUP_CYCLES)
    ) u_startup (
        .core_clk (core_clk),
        .rst      (rst),
        .tmr      (u_if.tmr)
    );

    // ------------------------------------------------------------------------
    // Analog controls
    // ------------------------------------------------------------------------
    // Registered so the analog switches never see decode glitches
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bandgap_reg <= 1'b0;
        end else begin
            bandgap_reg <= active;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            lp_reg <= 1'b0;
        end else begin
            lp_reg <= active && (mode_reg == vrc_pkg::MODE_LP);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            tr_reg <= 1'b0;
        end else begin
            tr_reg <= active && (mode_reg == vrc_pkg::MODE_TR);
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stable_d_reg <= 1'b0;
        end else begin
            stable_d_reg <= u_if.stable;
        end
    end

    always_comb begin
        ev                     = '0;
        ev[vrc_pkg::EV_STABLE] = u_if.stable && !stable_d_reg;
        ev[vrc_pkg::EV_LOST]   = !u_if.stable && stable_d_reg;
        ev[vrc_pkg::EV_RSVD]   = wr_sc && wr_data[vrc_pkg::SC_EN_BIT]
                                 && (wr_data[1:0] == vrc_pkg::MODE_RSVD);
    end

    // An event landing on a clearing write still sets its bit
    always_comb begin
        ista_next = ista_reg;
        if (wr_ista) begin
            ista_next = ista_next & ~wr_data[vrc_pkg::EV_W-1:0];
        end
        ista_next = ista_next | ev;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ista_reg <= '0;
        end else begin
            ista_reg <= ista_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            imsk_reg <= vrc_pkg::IMSK_RST;
        end else if (wr_imsk) begin
            imsk_reg <= wr_data[vrc_pkg::EV_W-1:0];
        end
    end

    // One cycle behind the status bits, traded for a clean flop output
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(ista_reg & imsk_reg);
        end
    end

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    always_comb begin
        rd_mux = '0;
        case (addr)
            vrc_pkg::ADDR_TRIM: begin
                rd_mux = trim_reg;
            end
            vrc_pkg::ADDR_SC: begin
                rd_mux[vrc_pkg::SC_EN_BIT] = en_reg;
                rd_mux[vrc_pkg::SC_ST_BIT] = u_if.stable;
                rd_mux[1:0]                = mode_reg;
            end
            vrc_pkg::ADDR_ISTA: begin
                rd_mux[vrc_pkg::EV_W-1:0] = ista_reg;
            end
            vrc_pkg::ADDR_IMSK: begin
                rd_mux[vrc_pkg::EV_W-1:0] = imsk_reg;
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    // Data is shown only in the cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_data_reg <= '0;
        end else if (rd_en) begin
            rd_data_reg <= rd_mux;
        end else begin
            rd_data_reg <= '0;
        end
    end

    assign rd_data    = rd_data_reg;
    assign trim_code  = trim_reg;
    assign bandgap_on = bandgap_reg;
    assign lp_buf_on  = lp_reg;
    assign tr_buf_on  = tr_reg;
    assign irq        = irq_reg;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    property p_trim;
        @(posedge core_clk) disable iff (rst)
        wr_trim |=> (trim_code == $past(wr_data));
    endproperty
    a_trim: assert property (p_trim)
        else $error("trim code not taken from write");

    property p_en_rdback;
        @(posedge core_clk) disable iff (rst)
        (wr_sc ##1 (rd_en && (addr == vrc_pkg::ADDR_SC) && !wr_en))
        |=> (rd_data[vrc_pkg::SC_EN_BIT] == $past(wr_data[vrc_pkg::SC_EN_BIT], 2));
    endproperty
    a_en_rdback: assert property (p_en_rdback)
        else $error("enable bit does not read back");

    property p_st_ro;
        @(posedge core_clk) disable iff (rst)
        (rd_en && (addr == vrc_pkg::ADDR_SC))
        |=> (rd_data[vrc_pkg::SC_ST_BIT] == $past(u_if.stable));
    endproperty
    a_st_ro: assert property (p_st_ro)
        else $error("stable bit read does not show timer state");

    property p_mode_rdback;
        @(posedge core_clk) disable iff (rst)
        (wr_sc ##1 (rd_en && (addr == vrc_pkg::ADDR_SC) && !wr_en))
        |=> (rd_data[1:0] == $past(wr_data[1:0], 2));
    endproperty
    a_mode_rdback: assert property (p_mode_rdback)
        else $error("mode field does not read back");

    property p_rsvd;
        @(posedge core_clk) disable iff (rst)
        (en_reg && (mode_reg == vrc_pkg::MODE_RSVD))
        |=> (!bandgap_on && !lp_buf_on && !tr_buf_on && !u_if.stable);
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved mode did not act as off");

    property p_off;
        @(posedge core_clk) disable iff (rst)
        !en_reg |=> (!bandgap_on && !lp_buf_on && !tr_buf_on);
    endproperty
    a_off: assert property (p_off)
        else $error("analog parts on while disabled");

    property p_stby;
        @(posedge core_clk) disable iff (rst)
        (en_reg && (mode_reg == vrc_pkg::MODE_STBY))
        |=> (bandgap_on && !lp_buf_on && !tr_buf_on);
    endproperty
    a_stby: assert property (p_stby)
        else $error("standby mode decode wrong");

    property p_lp;
        @(posedge core_clk) disable iff (rst)
        (en_reg && (mode_reg == vrc_pkg::MODE_LP))
        |=> (bandgap_on && lp_buf_on && !tr_buf_on);
    endproperty
    a_lp: assert property (p_lp)
        else $error("low-power mode decode wrong");

    property p_tr;
        @(posedge core_clk) disable iff (rst)
        (en_reg && (mode_reg == vrc_pkg::MODE_TR))
        |=> (bandgap_on && !lp_buf_on && tr_buf_on);
    endproperty
    a_tr: assert property (p_tr)
        else $error("tight-regulation mode decode wrong");

    property p_en_start;
        @(posedge core_clk) disable iff (rst)
        $rose(active) |-> !u_if.stable [*2];
    endproperty
    a_en_start: assert property (p_en_start)
        else $error("stable flag set right at enable");

    property p_keep;
        @(posedge core_clk) disable iff (rst)
        (u_if.stable && active && wr_sc && wr_data[vrc_pkg::SC_EN_BIT]
         && (wr_data[1:0] != vrc_pkg::MODE_RSVD)) |=> u_if.stable;
    endproperty
    a_keep: assert property (p_keep)
        else $error("mode change cleared stable flag");

    property p_irq;
        @(posedge core_clk) disable iff (rst)
        ##1 (irq == |($past(ista_reg) & $past(imsk_reg)));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt output disagrees with status and mask");

    property p_set_wins;
        @(posedge core_clk) disable iff (rst)
        (ev[vrc_pkg::EV_STABLE] && wr_ista) |=> ista_reg[vrc_pkg::EV_STABLE];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost under clearing write");

endmodule : vrc_regs

/* hw/vrc_startup.sv */
// Startup and stabilisation timer for the voltage reference
`timescale 1ns/1ps
module vrc_startup #(
    parameter int STARTUP_CYCLES = vrc_pkg::STARTUP_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    vrc_ctl_if.tmr   tmr
);

    localparam int            CW   = $clog2(STARTUP_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(STARTUP_CYCLES - 1);

    logic [CW-1:0] cnt_reg;
    logic          stable_reg;
    int            on_run_reg;

    // ------------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------------
    // Dropping ref_on clears the count, so the next enable starts afresh
    always_ff @(posedge core_clk) begin
        if (rst || !tmr.ref_on) begin
            cnt_reg <= '0;
        end else if (!stable_reg) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    // Only ref_on matters, so a mode swap among live modes keeps the flag
    always_ff @(posedge core_clk) begin
        if (rst || !tmr.ref_on) begin
            stable_reg <= 1'b0;
        end else if (cnt_reg == LAST) begin
            stable_reg <= 1'b1;
        end
    end

    assign tmr.stable = stable_reg;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst || !tmr.ref_on) begin
            on_run_reg <= 0;
        end else if (on_run_reg < STARTUP_CYCLES) begin
            on_run_reg <= on_run_reg + 1;
        end
    end

    property p_start_wait;
        @(posedge core_clk) disable iff (rst)
        (on_run_reg < STARTUP_CYCLES) |-> !tmr.stable;
    endproperty
    a_start_wait: assert property (p_start_wait)
        else $error("stable flag rose before startup time");

    property p_start_done;
        @(posedge core_clk) disable iff (rst)
        (on_run_reg >= STARTUP_CYCLES) |-> tmr.stable;
    endproperty
    a_start_done: assert property (p_start_done)
        else $error("stable flag missing after startup time");

endmodule : vrc_startup

/* tb/vrc_analog_model.sv */
// Behavioural model of the bandgap core and its two reference buffers
`timescale 1ns/1ps
module vrc_analog_model (
    input  wire logic              core_clk,
    input  wire logic        [7:0] trim_code,
    input  wire logic              bandgap_on,
    input  wire logic              lp_buf_on,
    input  wire logic              tr_buf_on,
    output logic signed      [7:0] trim_steps,
    output logic                   bad_combo
);
    // ------------------------------------------------------------------------
    // Trim offset from midpoint, in half-millivolt steps
    // ------------------------------------------------------------------------
    // Code 8'h80 is the highest output, all ones the midpoint, bit 7 clear below it
    assign trim_steps = $signed(~trim_code);

    // ------------------------------------------------------------------------
    // Illegal power combinations
    // ------------------------------------------------------------------------
    // A buffer with no bandgap behind it would drive garbage onto the reference
    always @(posedge core_clk) begin
        bad_combo <= ((lp_buf_on || tr_buf_on) && !bandgap_on)
                     || (lp_buf_on && tr_buf_on);
    end
endmodule : vrc_analog_model

/* tb/vrc_regs_test.sv */
// Self-checking testbench for the voltage reference register bank
`timescale 1ns/1ps
module vrc_regs_test;
    // Short startup count keeps the run brief; expectations derive from it
    localparam int STEPS = 8;

    logic              core_clk;
    logic              rst;
    logic        [7:0] addr;
    logic        [7:0] wr_data;
    logic              wr_en;
    logic              rd_en;
    logic        [7:0] rd_data;
    logic        [7:0] trim_code;
    logic              bandgap_on;
    logic              lp_buf_on;
    logic              tr_buf_on;
    logic              irq;
    logic signed [7:0] trim_steps;
    logic              bad_combo;
    logic        [7:0] rv;
    int                num_errors;
    int                check_count;

    vrc_regs #(.STARTUP_CYCLES(STEPS)) uut (
        .core_clk   (core_clk),
        .rst        (rst),
        .addr       (addr),
        .wr_data    (wr_data),
        .wr_en      (wr_en),
        .rd_en      (rd_en),
        .rd_data    (rd_data),
        .trim_code  (trim_code),
        .bandgap_on (bandgap_on),
        .lp_buf_on  (lp_buf_on),
        .tr_buf_on  (tr_buf_on),
        .irq        (irq)
    );

    vrc_analog_model analog (
        .core_clk   (core_clk),
        .trim_code  (trim_code),
        .bandgap_on (bandgap_on),
        .lp_buf_on  (lp_buf_on),
        .tr_buf_on  (tr_buf_on),
        .trim_steps (trim_steps),
        .bad_combo  (bad_combo)
    );

    // ------------------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        wr_en   <= 1'b1;
        addr    <= a;
        wr_data <= d;
        @(posedge core_clk);
        wr_en   <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask : rd

    // Analog controls are registered behind the register write
    task automatic settle();
        repeat (2) @(posedge core_clk);
        #1;
    endtask : settle

    task automatic check_outs(input logic bg, input logic lp, input logic tr);
        check("analog", {5'h00, bg, lp, tr}, {5'h00, bandgap_on, lp_buf_on, tr_buf_on});
        check("combo", 8'h00, {7'h00, bad_combo});
    endtask : check_outs

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset();
        check("trim_code", 8'hff, trim_code);
        rd(8'h00, rv);
        check("trim", 8'hff, rv);
        rd(8'h01, rv);
        check("sc", 8'h00, rv);
        check_outs(1'b0, 1'b0, 1'b0);
        check("irq", 8'h00, {7'h00, irq});
    endtask : t_reset

    task automatic t_trim();
        logic [7:0] codes [4];
        logic [7:0] steps [4];
        codes = '{8'h80, 8'h7f, 8'h00, 8'hff};
        steps = '{8'h7f, 8'h80, 8'hff, 8'h00};
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, codes[i]);
            rd(8'h00, rv);
            check("trim", codes[i], rv);
            check("trim_steps", steps[i], trim_steps);
        end
    endtask : t_trim

    task automatic t_modes();
        logic en;
        for (int e = 0; e < 2; e++) begin
            for (int m = 0; m < 4; m++) begin
                en = e[0];
                wr(8'h01, {en, 5'h00, m[1:0]});
                settle();
                check_outs(en && m != 3, en && m == 1, en && m == 2);
                rd(8'h01, rv);
                check("sc", {en, 5'h00, m[1:0]}, rv & 8'hfb);
            end
        end
        // Reserved mode must never report a settled reference
        repeat (STEPS + 4) @(posedge core_clk);
        rd(8'h01, rv);
        check("sc reserved", 8'h83, rv);
        wr(8'h01, 8'h00);
    endtask : t_modes

    task automatic t_startup();
        settle();
        wr(8'h01, 8'h80);
        repeat (STEPS - 3) @(posedge core_clk);
        rd(8'h01, rv);
        check("sc early", 8'h80, rv);
        repeat (4) @(posedge core_clk);
        rd(8'h01, rv);
        check("sc stable", 8'h84, rv);
        wr(8'h01, 8'h82);
        rd(8'h01, rv);
        check("sc mode change", 8'h86, rv);
        settle();
        check_outs(1'b1, 1'b0, 1'b1);
        wr(8'h01, 8'h81);
        rd(8'h01, rv);
        check("sc mode change", 8'h85, rv);
        wr(8'h01, 8'h01);
        rd(8'h01, rv);
        check("sc disabled", 8'h01, rv);
        wr(8'h01, 8'h80);
        repeat (3) @(posedge core_clk);
        rd(8'h01, rv);
        check("sc restart", 8'h80, rv);
        wr(8'h01, 8'h00);
    endtask : t_startup

    task automatic t_irq();
        settle();
        rd(8'h02, rv);
        check("irq status", 8'h07, rv);
        check("irq masked", 8'h00, {7'h00, irq});
        wr(8'h03, 8'h07);
        settle();
        check("irq raised", 8'h01, {7'h00, irq});
        wr(8'h02, 8'h07);
        settle();
        check("irq cleared", 8'h00, {7'h00, irq});
        rd(8'h02, rv);
        check("irq status", 8'h00, rv);
        wr(8'h01, 8'h80);
        repeat (STEPS + 4) @(posedge core_clk);
        #1;
        check("irq stable", 8'h01, {7'h00, irq});
        rd(8'h02, rv);
        check("irq status", 8'h01, rv);
        wr(8'h03, 8'h00);
        settle();
        check("irq mask off", 8'h00, {7'h00, irq});
        // Unmapped place: writes vanish, reads give zero
        wr(8'h10, 8'h55);
        rd(8'h10, rv);
        check("unmapped", 8'h00, rv);
        rd(8'h00, rv);
        check("trim kept", 8'hff, rv);
    endtask : t_irq

    // Clearing write meets the stable event in one cycle; the event must survive
    task automatic t_set_wins();
        wr(8'h01, 8'h00);
        settle();
        wr(8'h02, 8'h07);
        wr(8'h01, 8'h80);
        repeat (STEPS - 1) @(posedge core_clk);
        wr(8'h02, 8'h01);
        rd(8'h02, rv);
        check("status set wins", 8'h01, rv);
    endtask : t_set_wins

    // Reset in mid-run, with the reference live and an interrupt raised
    task automatic t_rerun();
        wr(8'h00, 8'h12);
        wr(8'h03, 8'h07);
        settle();
        check("irq before reset", 8'h01, {7'h00, irq});
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        check("trim_code reset", 8'hff, trim_code);
        check_outs(1'b0, 1'b0, 1'b0);
        check("irq reset", 8'h00, {7'h00, irq});
        rd(8'h01, rv);
        check("sc reset", 8'h00, rv);
    endtask : t_rerun

    // ------------------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    initial begin
        rst         = 1'b1;
        wr_en       = 1'b0;
        rd_en       = 1'b0;
        addr        = 8'h00;
        wr_data     = 8'h00;
        num_errors  = 0;
        check_count = 0;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        t_reset();
        t_trim();
        t_modes();
        t_startup();
        t_irq();
        t_set_wins();
        t_rerun();
        conclude();
    end

    // Whole sequence needs well under a thousand cycles
    initial begin
        #200000;
        num_errors++;
        conclude();
    end
endmodule : vrc_regs_test
